// >>> src/multidrop_packet_receiver.sv
// receive framing, address acceptance and reply decision for the multi-drop control bus
// assumes rx_valid strobes one byte per cycle at most, synchronous to clk
// Functional notes
// - accept own type override id always
// - broadcast executed, never answered
// - answer non-broadcast override ids
// - return fixed equipment type code
// - modem accepts legacy ids 01, 02
// - extra data bytes silently ignored
// - bulk reply: params, status, param count
// - new fields appended after existing sections
// - command wait timeout leaves wait state
// - flag errors, discard, keep counting bytes
// - follow whole packet, then hunt sync
// - clean: execute, ack; error: error code
// - packets start with 0x16 sync
// - checksum is mod-256 sum after sync
// - reply swaps ids, opcode zero if clean
// - repeated sequence number acked, not executed
`timescale 1ns/1ps
`default_nettype none
module multidrop_packet_receiver
  import mdrx_pkg::*;
#(
  parameter int TIMEOUT_CYC = CMD_TIMEOUT_CYC,
  parameter logic [7:0] TYPE_ID_MOD = 8'hA1,   // arbitrary value
  parameter logic [7:0] TYPE_ID_DEMOD = 8'hA2, // arbitrary value
  parameter logic [7:0] TYPE_ID_MODEM = 8'hA3  // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] own_addr,
  input wire logic [1:0] equip_cfg,
  input wire logic [3:0] payload_raddr,
  output logic cmd_valid,
  output logic cmd_execute,
  output logic reply_req,
  output logic [7:0] reply_src,
  output logic [7:0] reply_dst,
  output logic [7:0] reply_fsn,
  output logic [15:0] reply_opcode,
  output logic [15:0] cmd_opcode,
  output logic [15:0] cmd_len,
  output logic [7:0] payload_rdata,
  output logic [7:0] type_code,
  output logic cmd_timeout
);
  function automatic logic [7:0] type_id(input logic [1:0] cfg);
    unique case (cfg)
      CFG_MOD_ONLY: type_id = TYPE_ID_MOD;
      CFG_DEMOD_ONLY: type_id = TYPE_ID_DEMOD;
      default: type_id = TYPE_ID_MODEM;
    endcase
  endfunction : type_id

  mdrx_payload_if pif ();
  mdrx_payload_mem u_mem (.clk(clk), .bus(pif.store));

  rx_state_t state_reg, state_next;
  logic [2:0] hidx_reg, hidx_next;
  logic [CNT_W-1:0] left_reg, left_next, len_reg, len_next, didx_reg, didx_next;
  logic [7:0] sum_reg, sum_next, src_reg, src_next, dst_reg, dst_next, fsn_reg, fsn_next;
  logic [15:0] op_reg, op_next;
  logic err_reg, err_next, toolong_reg, toolong_next;
  logic [7:0] last_fsn_reg, last_fsn_next;
  logic fsn_seen_reg, fsn_seen_next;
  logic cmd_valid_next, cmd_execute_next, reply_req_next, timeout_next;
  logic [7:0] reply_src_next, reply_dst_next, reply_fsn_next;
  logic [15:0] reply_op_next, cmd_op_next, cmd_len_next;
  logic [31:0] wait_reg, wait_next;
  logic accept, is_bcast, legacy_hit;

  always_comb begin
    is_bcast = (dst_reg == ID_BROADCAST);
    legacy_hit = (equip_cfg == CFG_MODEM) && (dst_reg == ID_LEGACY_MOD || dst_reg == ID_LEGACY_DEMOD);
    accept = (dst_reg == own_addr) || (dst_reg == type_id(equip_cfg)) || is_bcast || legacy_hit;
  end

  always_comb begin
    state_next = state_reg;
    hidx_next = hidx_reg;
    left_next = left_reg;
    len_next = len_reg;
    didx_next = didx_reg;
    sum_next = sum_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    fsn_next = fsn_reg;
    op_next = op_reg;
    err_next = err_reg;
    toolong_next = toolong_reg;
    last_fsn_next = last_fsn_reg;
    fsn_seen_next = fsn_seen_reg;
    cmd_valid_next = 1'b0;
    cmd_execute_next = 1'b0;
    reply_req_next = 1'b0;
    reply_src_next = reply_src;
    reply_dst_next = reply_dst;
    reply_fsn_next = reply_fsn;
    reply_op_next = reply_opcode;
    cmd_op_next = cmd_opcode;
    cmd_len_next = cmd_len;
    pif.we = 1'b0;
    pif.waddr = didx_reg[3:0];
    pif.wdata = rx_byte;
    unique case (state_reg)
      ST_HUNT: begin
        if (rx_valid && rx_byte == FRAME_START) begin
          state_next = ST_HEADER;
          hidx_next = 3'h0;
          sum_next = 8'h00;
          err_next = 1'b0;
          toolong_next = 1'b0;
        end
      end
      ST_HEADER: begin
        if (rx_valid) begin
          sum_next = sum_reg + rx_byte;
          hidx_next = hidx_reg + 3'h1;
          unique case (hidx_reg)
            3'h0: len_next = {rx_byte, len_reg[7:0]};
            3'h1: len_next = {len_reg[15:8], rx_byte};
            3'h2: src_next = rx_byte;
            3'h3: dst_next = rx_byte;
            3'h4: fsn_next = rx_byte;
            3'h5: op_next = {rx_byte, op_reg[7:0]};
            default: op_next = {op_reg[15:8], rx_byte};
          endcase
          if (hidx_reg == 3'(HDR_LEN - 1)) begin
            didx_next = '0;
            left_next = len_reg;
            toolong_next = (len_reg > MAX_DATA_LEN);
            state_next = (len_reg == '0) ? ST_SUM : ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (rx_valid) begin
          sum_next = sum_reg + rx_byte;
          // bytes past the kept window are summed but otherwise dropped
          // fields appended by newer hosts land past the kept window and fall out here
          pif.we = accept && (didx_reg < CNT_W'(PAYLOAD_KEEP));
          didx_next = didx_reg + 1'b1;
          left_next = left_reg - 1'b1;
          if (left_reg == 16'h0001) begin
            state_next = ST_SUM;
          end
        end
      end
      ST_SUM: begin
        if (rx_valid) begin
          err_next = (rx_byte != sum_reg) || toolong_reg;
          state_next = ST_DELIVER;
        end
      end
      ST_DELIVER: begin
        state_next = ST_HUNT;
        if (accept) begin
          cmd_valid_next = 1'b1;
          cmd_op_next = op_reg;
          // the handed-on count lets the reply builder size its parameter and status sections
          cmd_len_next = len_reg;
          reply_src_next = dst_reg;
          reply_dst_next = src_reg;
          reply_fsn_next = fsn_reg;
          if (err_reg) begin
            reply_op_next = toolong_reg ? OP_TOO_LONG : OP_BAD_CHECKSUM;
          end else begin
            reply_op_next = OP_GOOD;
            // duplicate sequence: acknowledge again, do not run it twice
            cmd_execute_next = !(fsn_seen_reg && fsn_reg == last_fsn_reg);
            last_fsn_next = fsn_reg;
            fsn_seen_next = 1'b1;
          end
          reply_req_next = !is_bcast;
        end
      end
      default: state_next = ST_HUNT;
    endcase
  end

  // command wait timer, restarted by every accepted packet
  always_comb begin
    timeout_next = 1'b0;
    wait_next = wait_reg + 32'h1;
    if (cmd_valid_next) begin
      wait_next = 32'h0;
    end else if (wait_reg >= 32'(TIMEOUT_CYC - 1)) begin
      wait_next = 32'h0;
      timeout_next = 1'b1;
    end
  end

  assign pif.raddr = payload_raddr;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_HUNT;
      hidx_reg <= 3'h0;
      left_reg <= '0;
      len_reg <= '0;
      didx_reg <= '0;
      sum_reg <= 8'h00;
      src_reg <= 8'h00;
      dst_reg <= 8'h00;
      fsn_reg <= 8'h00;
      op_reg <= 16'h0000;
      err_reg <= 1'b0;
      toolong_reg <= 1'b0;
      last_fsn_reg <= 8'h00;
      fsn_seen_reg <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_execute <= 1'b0;
      reply_req <= 1'b0;
      reply_src <= 8'h00;
      reply_dst <= 8'h00;
      reply_fsn <= 8'h00;
      reply_opcode <= 16'h0000;
      cmd_opcode <= 16'h0000;
      cmd_len <= 16'h0000;
      wait_reg <= 32'h0;
      cmd_timeout <= 1'b0;
      type_code <= 8'h00;
      payload_rdata <= 8'h00;
    end else begin
      state_reg <= state_next;
      hidx_reg <= hidx_next;
      left_reg <= left_next;
      len_reg <= len_next;
      didx_reg <= didx_next;
      sum_reg <= sum_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      fsn_reg <= fsn_next;
      op_reg <= op_next;
      err_reg <= err_next;
      toolong_reg <= toolong_next;
      last_fsn_reg <= last_fsn_next;
      fsn_seen_reg <= fsn_seen_next;
      cmd_valid <= cmd_valid_next;
      cmd_execute <= cmd_execute_next;
      reply_req <= reply_req_next;
      reply_src <= reply_src_next;
      reply_dst <= reply_dst_next;
      reply_fsn <= reply_fsn_next;
      reply_opcode <= reply_op_next;
      cmd_opcode <= cmd_op_next;
      cmd_len <= cmd_len_next;
      wait_reg <= wait_next;
      cmd_timeout <= timeout_next;
      type_code <= type_id(equip_cfg);
      payload_rdata <= pif.rdata;
    end
  end

  AST_BCAST_SILENT: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && is_bcast) |=> cmd_valid && !reply_req)
    else $error("broadcast packet answered");
  AST_OVERRIDE_REPLY: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && dst_reg == type_id(equip_cfg) && !is_bcast) |=> reply_req)
    else $error("override packet not answered");
  AST_OWN_TYPE_ACCEPT: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && dst_reg == type_id(equip_cfg)) |=> cmd_valid)
    else $error("type override packet dropped");
  AST_LEGACY: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && equip_cfg == CFG_MODEM && dst_reg == ID_LEGACY_MOD) |=> cmd_valid)
    else $error("legacy id not accepted");
  AST_FOREIGN: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && !accept) |=> !cmd_valid && !reply_req)
    else $error("foreign packet accepted");
  AST_SWAP: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && accept) |=> reply_src == $past(dst_reg) && reply_dst == $past(src_reg))
    else $error("reply ids not swapped");
  AST_ERR_NO_EXEC: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && err_reg) |=> !cmd_execute)
    else $error("errored packet executed");
  AST_BAD_SUM: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_SUM && rx_valid && rx_byte != sum_reg) |=> ##1 (!cmd_valid || reply_opcode != OP_GOOD))
    else $error("checksum error not reported");
  AST_RESYNC: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER) |=> state_reg == ST_HUNT)
    else $error("no return to hunt");
  AST_DUP: assert property (@(posedge clk) disable iff (rst)
    (state_reg == ST_DELIVER && accept && !err_reg && fsn_seen_reg && fsn_reg == last_fsn_reg)
      |=> cmd_valid && !cmd_execute)
    else $error("duplicate executed");
  AST_TIMEOUT_RESTART: assert property (@(posedge clk) disable iff (rst)
    cmd_valid |-> wait_reg == 32'h0)
    else $error("wait timer not restarted");
  COV_EXEC: cover property (@(posedge clk) disable iff (rst) cmd_execute && reply_req);
  COV_BCAST: cover property (@(posedge clk) disable iff (rst) cmd_valid && !reply_req);
  COV_ERR: cover property (@(posedge clk) disable iff (rst) cmd_valid && reply_opcode == OP_BAD_CHECKSUM);
  COV_TIMEOUT: cover property (@(posedge clk) disable iff (rst) cmd_timeout);
  COV_TOO_LONG: cover property (@(posedge clk) disable iff (rst) cmd_valid && reply_opcode == OP_TOO_LONG);
endmodule : multidrop_packet_receiver
`default_nettype wire

// >>> src/mdrx_pkg.sv
// package for the multi-drop packet receiver: link constants, ids, opcodes, timing
// assumes one 10 MHz system clock, bytes arrive as one-cycle strobes
package mdrx_pkg;
  localparam logic [7:0] FRAME_START = 8'h16;
  localparam logic [7:0] ID_BROADCAST = 8'h00;
  localparam logic [7:0] ID_LEGACY_MOD = 8'h01;
  localparam logic [7:0] ID_LEGACY_DEMOD = 8'h02;
  localparam logic [1:0] CFG_MOD_ONLY = 2'h0;
  localparam logic [1:0] CFG_DEMOD_ONLY = 2'h1;
  localparam logic [1:0] CFG_MODEM = 2'h2;
  localparam logic [15:0] OP_GOOD = 16'h0000;
  localparam logic [15:0] OP_BAD_CHECKSUM = 16'h00FD;
  localparam logic [15:0] OP_TOO_LONG = 16'h00F8;
  localparam int CLK_HZ = 10_000_000;
  localparam int CMD_TIMEOUT_MS = 200;
  localparam int CMD_TIMEOUT_CYC = CMD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int HDR_LEN = 7;
  localparam int PAYLOAD_KEEP = 16;
  localparam logic [15:0] MAX_DATA_LEN = 16'h0400;
  localparam int CNT_W = 16;
  typedef enum logic [2:0] {
    ST_HUNT, ST_HEADER, ST_DATA, ST_SUM, ST_DELIVER
  } rx_state_t;
endpackage : mdrx_pkg

// >>> src/mdrx_payload_if.sv
// interface carrying payload writes from the receiver into the payload store
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface mdrx_payload_if;
  logic we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  modport writer(output we, output waddr, output wdata, output raddr, input rdata);
  modport store(input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mdrx_payload_if
`default_nettype wire

// >>> src/mdrx_payload_mem.sv
// small payload store for the understood leading data bytes, registered read
// assumes writer and reader on clk
`timescale 1ns/1ps
`default_nettype none
module mdrx_payload_mem (
  input wire logic clk,
  mdrx_payload_if.store bus
);
  logic [7:0] mem [0:15];
  logic [7:0] rdata_reg;
  always_ff @(posedge clk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
    rdata_reg <= mem[bus.raddr];
  end
  assign bus.rdata = rdata_reg;
endmodule : mdrx_payload_mem
`default_nettype wire

// >>> testbench/mdrx_host_model.sv
// host model: sends framed packets one byte per cycle on the receive strobe
// assumes the receiver takes rx_byte on the rising clk edge while rx_valid is high
`timescale 1ns/1ps
`default_nettype none
module mdrx_host_model (
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic clk
);
  logic [7:0] pay [0:31];
  logic [7:0] last;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'hFF;
  end
  task automatic put(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    last = b;
  endtask : put
  task automatic send(input logic [7:0] src, input logic [7:0] dst, input logic [7:0] fsn,
                      input logic [15:0] op, input logic [15:0] len, input bit bad, input int junk);
    logic [7:0] sum;
    sum = len[15:8] + len[7:0] + src + dst + fsn + op[15:8] + op[7:0];
    repeat (junk) put(8'h4C);
    put(8'h16);
    put(len[15:8]);
    put(len[7:0]);
    put(src);
    put(dst);
    put(fsn);
    put(op[15:8]);
    put(op[7:0]);
    // the count alone sets the frame length; long frames reuse the stored bytes cyclically
    for (int i = 0; i < len; i++) begin
      put(pay[i % 32]);
      sum = sum + pay[i % 32];
    end
    put(bad ? ~sum : sum);
    @(posedge clk);
    rx_valid <= 1'b0;
    // released line shows no stale byte; callers leave the gap before the next frame
    rx_byte <= ~last;
  endtask : send
endmodule : mdrx_host_model
`default_nettype wire

// >>> testbench/multidrop_packet_receiver_test.sv
// self-checking bench for the multi-drop packet receiver
// assumes mdrx_host_model drives the byte strobe; short command timeout for simulation
`timescale 1ns/1ps
`default_nettype none
module multidrop_packet_receiver_test;
  import mdrx_pkg::*;
  localparam int TMO = 50;
  localparam logic [7:0] TMOD = 8'hB1; // arbitrary value
  localparam logic [7:0] TDEMOD = 8'hB2; // arbitrary value
  localparam logic [7:0] TMODEM = 8'hB3; // arbitrary value
  logic clk, rst, rx_valid, cmd_valid, cmd_execute, reply_req, cmd_timeout;
  logic [7:0] rx_byte, own_addr, reply_src, reply_dst, reply_fsn, payload_rdata, type_code;
  logic [1:0] equip_cfg;
  logic [3:0] payload_raddr;
  logic [15:0] reply_opcode, cmd_opcode, cmd_len;
  logic [7:0] tid [0:2] = '{TMOD, TDEMOD, TMODEM};
  logic [7:0] fsn_ctr = 8'h10;
  logic [7:0] last_fsn = 8'h00;
  int num_errors = 0;
  int comparisons = 0;
  int unsigned seed_dummy;
  multidrop_packet_receiver #(.TIMEOUT_CYC(TMO), .TYPE_ID_MOD(TMOD), .TYPE_ID_DEMOD(TDEMOD),
    .TYPE_ID_MODEM(TMODEM)) dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .own_addr(own_addr), .equip_cfg(equip_cfg), .payload_raddr(payload_raddr), .cmd_valid(cmd_valid),
    .cmd_execute(cmd_execute), .reply_req(reply_req), .reply_src(reply_src), .reply_dst(reply_dst),
    .reply_fsn(reply_fsn), .reply_opcode(reply_opcode), .cmd_opcode(cmd_opcode), .cmd_len(cmd_len),
    .payload_rdata(payload_rdata), .type_code(type_code), .cmd_timeout(cmd_timeout));
  mdrx_host_model host (.rx_valid(rx_valid), .rx_byte(rx_byte), .clk(clk));
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // rep of x means the reply decision is not judged for this address
  task automatic run_pkt(input logic [7:0] dst, input int len, input bit bad, input bit dup,
                         input bit acc, input bit exe, input logic rep);
    logic [7:0] src;
    logic [7:0] fsn;
    logic [15:0] op;
    logic [15:0] want_op;
    bit err;
    int n;
    src = 8'($urandom);
    op = 16'($urandom);
    fsn = dup ? last_fsn : fsn_ctr;
    fsn_ctr = fsn_ctr + 8'h01;
    want_op = (len > int'(MAX_DATA_LEN)) ? OP_TOO_LONG : (bad ? OP_BAD_CHECKSUM : OP_GOOD);
    err = (want_op != OP_GOOD);
    for (int i = 0; i < len && i < 32; i++) begin
      host.pay[i] = 8'($urandom);
    end
    host.send(src, dst, fsn, op, 16'(len), bad, 2);
    n = 0;
    @(posedge clk);
    #1;
    while (cmd_valid !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(cmd_valid), 16'(acc), "accept");
    if (acc) begin
      check(16'(cmd_execute), 16'(exe), "execute");
      if (rep !== 1'bx) check(16'(reply_req), 16'(rep), "reply");
      check(16'(reply_src), 16'(dst), "reply source");
      check(16'(reply_dst), 16'(src), "reply dest");
      check(16'(reply_fsn), 16'(fsn), "reply fsn");
      check(reply_opcode, want_op, "reply opcode");
      check(cmd_len, 16'(len), "length");
      if (!err) begin
        last_fsn = fsn;
        check(cmd_opcode, op, "opcode");
        for (int i = 0; i < len && i < 16; i++) begin
          @(posedge clk);
          payload_raddr <= 4'(i);
          repeat (3) @(posedge clk);
          #1;
          check(16'(payload_rdata), 16'(host.pay[i]), "payload");
        end
      end
    end
  endtask : run_pkt
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("BAD t=%0t run did not finish", $time);
    wrap_up();
  end
  initial begin
    int n;
    rst = 1'b1;
    equip_cfg = CFG_MODEM;
    payload_raddr = 4'h0;
    seed_dummy = $urandom(18811);
    // drawn during reset so the first packet already sees the final address
    own_addr = 8'($urandom_range(8'h7F, 8'h40));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run_pkt(own_addr, 0, 0, 0, 1, 1, 1);
    run_pkt(own_addr, 3, 0, 1, 1, 0, 1);
    run_pkt(own_addr, 5, 1, 0, 1, 0, 1);
    run_pkt(ID_BROADCAST, 2, 0, 0, 1, 1, 0);
    run_pkt(ID_BROADCAST, 2, 1, 0, 1, 0, 0);
    run_pkt(own_addr ^ 8'h80, 20, 0, 0, 0, 0, 0);
    run_pkt(own_addr, 20, 0, 0, 1, 1, 1);
    run_pkt(own_addr, int'(MAX_DATA_LEN) + 1, 0, 0, 1, 0, 1);
    for (int c = 0; c < 3; c++) begin
      @(posedge clk);
      equip_cfg <= 2'(c);
      repeat (3) @(posedge clk);
      #1;
      check(16'(type_code), 16'(tid[c]), "type code");
      run_pkt(tid[c], 1, 0, 0, 1, 1, 1);
      run_pkt(tid[(c + 1) % 3], 0, 0, 0, 0, 0, 0);
      run_pkt(ID_LEGACY_MOD, 0, 0, 0, c == 2, c == 2, 1'b1);
      run_pkt(ID_LEGACY_DEMOD, 0, 0, 0, c == 2, c == 2, 1'b1);
    end
    repeat (8) run_pkt(own_addr, $urandom_range(20, 0), 0, 0, 1, 1, 1);
    run_pkt(own_addr, 0, 0, 0, 1, 1, 1);
    n = 0;
    while (cmd_timeout !== 1'b1 && n < TMO + 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n), 16'(TMO), "timeout");
    wrap_up();
  end
endmodule : multidrop_packet_receiver_test
`default_nettype wire
